// ---- rtl/c2h_perf_pkg.sv ----
/*
   register offsets, field positions and reset values of the card_to_host
   channel performance monitor and interrupt enable mask.
   assumes byte addressing, one 32-bit word per register.
*/
package c2h_perf_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W  = 42;
   localparam int LO_W   = 32;
   localparam int HI_W   = CNT_W - LO_W;

   localparam logic [ADDR_W-1:0] OFF_MASK      = 8'h90;
   localparam logic [ADDR_W-1:0] OFF_MASK_SET  = 8'h94;
   localparam logic [ADDR_W-1:0] OFF_MASK_CLR  = 8'h98;
   localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'hC0;
   localparam logic [ADDR_W-1:0] OFF_CYC_LO    = 8'hC4;
   localparam logic [ADDR_W-1:0] OFF_CYC_HI    = 8'hC8;
   localparam logic [ADDR_W-1:0] OFF_BEAT_LO   = 8'hCC;
   localparam logic [ADDR_W-1:0] OFF_BEAT_HI   = 8'hD0;

   localparam int CTRL_AUTO_BIT  = 0;
   localparam int CTRL_CLEAR_BIT = 1;
   localparam int CTRL_RUN_BIT   = 2;
   localparam int MAXED_BIT      = 16;

   // implemented mask bits: 23:19, 13:9, 6, 4, 2, 1
   localparam logic [DATA_W-1:0] MASK_VALID = 32'h00F8_3E56;
   localparam logic [DATA_W-1:0] MASK_RESET = 32'h0000_0000;
   localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  CNT_RESET  = {CNT_W{1'b0}};
   localparam logic [CNT_W-1:0]  CNT_MAX    = {CNT_W{1'b1}};
   localparam logic [CNT_W-1:0]  CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
endpackage

// ---- rtl/c2h_perf_monitor.sv ----
/*
   performance monitor of one card_to_host channel plus the set/clear alias
   ports of its interrupt enable mask, on a simple synchronous register port.
   assumes chan_run_in, stop_desc_done_in, rd_beat_valid_in and
   status_events_in come from engine logic on clk_in (no synchroniser).
*/
// Behaviour
// R1: a write to the set alias sets every mask bit whose data bit is 1 and keeps the others.
// R2: a write to the clear alias clears every mask bit whose data bit is 1 and keeps the others.
// R3: each mask bit lets its logged status event raise the channel interrupt request.
// R4: monitor run written 1 arms the counters, which count only while channel run is also set.
// R5: monitor run written 0 halts both counters, which keep their values.
// R6: writing 1 to the write-only clear bit zeroes both counters and flags and is not stored.
// R7: in auto mode, completing a descriptor with the stop flag stops both counters.
// R8: in auto mode, both counters are zeroed whenever channel run becomes set.
// R9: that automatic zeroing happens on the zero-to-one edge of channel run.
// R10: software must still set monitor run itself, as auto mode never arms counting.
// R11: the cycle counter is 42 bits, counts every running clock, low word then bits 41:32.
// R12: the cycle saturation flag in bit 16 of its high word sets when the count hits maximum.
// R13: the beat counter is 42 bits and counts each valid read beat while running.
// R14: the beat saturation flag in bit 16 of its high word sets when the count hits maximum.
// R15: after reset all counter words and control bits read zero; counters are read-only.
// R16: a counter at maximum holds there until cleared by software or auto mode.
`timescale 1ns/1ps
module c2h_perf_monitor
(
   input  wire logic                              clk_in,
   input  wire logic                              rst_n_in,
   input  wire logic [c2h_perf_pkg::ADDR_W-1:0]   reg_addr_in,
   input  wire logic                              reg_wr_in,
   input  wire logic [c2h_perf_pkg::DATA_W-1:0]   reg_wdata_in,
   input  wire logic                              reg_rd_in,
   output logic      [c2h_perf_pkg::DATA_W-1:0]   reg_rdata_out,
   input  wire logic                              chan_run_in,
   input  wire logic                              stop_desc_done_in,
   input  wire logic                              rd_beat_valid_in,
   input  wire logic [c2h_perf_pkg::DATA_W-1:0]   status_events_in,
   output logic      [c2h_perf_pkg::DATA_W-1:0]   int_mask_out,
   output logic                                   chan_irq_out
);
   import c2h_perf_pkg::*;

   typedef struct packed
   {
      logic [DATA_W-1:0] mask;
      logic              mon_run;
      logic              mon_auto;
      logic              chan_run_prev;
      logic [CNT_W-1:0]  cyc;
      logic              cyc_max;
      logic [CNT_W-1:0]  beat;
      logic              beat_max;
      logic [DATA_W-1:0] rdata;
      logic              irq;
   } state_t;

   localparam state_t STATE_RESET = '{
      mask:          MASK_RESET,
      mon_run:       1'b0,
      mon_auto:      1'b0,
      chan_run_prev: 1'b0,
      cyc:           CNT_RESET,
      cyc_max:       1'b0,
      beat:          CNT_RESET,
      beat_max:      1'b0,
      rdata:         WORD_ZERO,
      irq:           1'b0
   };

   state_t state_reg;
   state_t state_next;

   logic wr_mask;
   logic wr_set;
   logic wr_clr;
   logic wr_ctrl;
   logic sw_clear;
   logic run_rise;
   logic auto_zero;
   logic counting;

   always_comb
   begin
      wr_mask   = reg_wr_in && (reg_addr_in == OFF_MASK);
      wr_set    = reg_wr_in && (reg_addr_in == OFF_MASK_SET);
      wr_clr    = reg_wr_in && (reg_addr_in == OFF_MASK_CLR);
      wr_ctrl   = reg_wr_in && (reg_addr_in == OFF_CTRL);
      sw_clear  = wr_ctrl && reg_wdata_in[CTRL_CLEAR_BIT];                   // see R6
      run_rise  = chan_run_in && !state_reg.chan_run_prev;                   // see R9
      auto_zero = state_reg.mon_auto && run_rise;                            // see R8
      // armed alone is not enough: the engine must be running too
      counting  = state_reg.mon_run && chan_run_in;                          // see R4
   end

   always_comb
   begin
      state_next = state_reg;
      state_next.chan_run_prev = chan_run_in;

      // mask: direct word, then set alias, then clear alias
      if (wr_mask)
      begin
         state_next.mask = reg_wdata_in & MASK_VALID;
      end
      if (wr_set)
      begin
         state_next.mask = state_reg.mask | (reg_wdata_in & MASK_VALID);      // see R1
      end
      if (wr_clr)
      begin
         state_next.mask = state_reg.mask & ~reg_wdata_in;                   // see R2
      end

      // auto stop drops the armed bit; a run write in the same cycle wins
      if (state_reg.mon_auto && stop_desc_done_in)
      begin
         state_next.mon_run = 1'b0;                                          // see R7
      end
      if (wr_ctrl)
      begin
         state_next.mon_run  = reg_wdata_in[CTRL_RUN_BIT];                   // see R5
         state_next.mon_auto = reg_wdata_in[CTRL_AUTO_BIT];
      end

      // counters: clear and auto zero take priority over counting
      if (sw_clear || auto_zero)
      begin
         state_next.cyc      = CNT_RESET;                                    // see R6
         state_next.cyc_max  = 1'b0;
         state_next.beat     = CNT_RESET;                                    // see R8
         state_next.beat_max = 1'b0;
      end
      else if (counting)
      begin
         if (state_reg.cyc != CNT_MAX)                                       // see R16
         begin
            state_next.cyc = state_reg.cyc + CNT_ONE;                        // see R11
         end
         if (state_next.cyc == CNT_MAX)
         begin
            state_next.cyc_max = 1'b1;                                       // see R12
         end
         // saturate instead of wrapping so the flag never lies about the count
         if (rd_beat_valid_in && (state_reg.beat != CNT_MAX))
         begin
            state_next.beat = state_reg.beat + CNT_ONE;                      // see R13
         end
         if (state_next.beat == CNT_MAX)
         begin
            state_next.beat_max = 1'b1;                                      // see R14
         end
      end

      state_next.irq = |(status_events_in & state_reg.mask);                 // see R3

      // read data registered; counter words ignore writes
      state_next.rdata = WORD_ZERO;
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            OFF_MASK:
            begin
               state_next.rdata = state_reg.mask;
            end
            OFF_CTRL:
            begin
               state_next.rdata[CTRL_RUN_BIT]  = state_reg.mon_run;
               state_next.rdata[CTRL_AUTO_BIT] = state_reg.mon_auto;
            end
            OFF_CYC_LO:
            begin
               state_next.rdata = state_reg.cyc[LO_W-1:0];                   // see R15
            end
            OFF_CYC_HI:
            begin
               state_next.rdata[HI_W-1:0] = state_reg.cyc[CNT_W-1:LO_W];     // see R11
               state_next.rdata[MAXED_BIT] = state_reg.cyc_max;
            end
            OFF_BEAT_LO:
            begin
               state_next.rdata = state_reg.beat[LO_W-1:0];
            end
            OFF_BEAT_HI:
            begin
               state_next.rdata[HI_W-1:0] = state_reg.beat[CNT_W-1:LO_W];    // see R13
               state_next.rdata[MAXED_BIT] = state_reg.beat_max;
            end
            default:
            begin
               state_next.rdata = WORD_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= STATE_RESET;                                           // see R15
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata_out = state_reg.rdata;
   assign int_mask_out  = state_reg.mask;
   assign chan_irq_out  = state_reg.irq;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   AST_MASK_SET: assert property (                                           // see R1
      (wr_set && !wr_clr) |=> ((int_mask_out & $past(reg_wdata_in) & MASK_VALID)
                               == ($past(reg_wdata_in) & MASK_VALID)))
      else $error("set alias did not set mask bits");

   AST_MASK_CLR: assert property (                                           // see R2
      wr_clr |=> ((int_mask_out & $past(reg_wdata_in)) == WORD_ZERO))
      else $error("clear alias did not clear mask bits");

   AST_IRQ_GATE: assert property (                                           // see R3
      ##1 chan_irq_out == $past(|(status_events_in & int_mask_out)))
      else $error("interrupt request does not match masked events");

   AST_ARMED_IDLE: assert property (                                         // see R4
      (!chan_run_in && !sw_clear && !auto_zero) |=> $stable(state_reg.cyc))
      else $error("cycle counter moved while channel not running");

   AST_HALT_HOLD: assert property (                                          // see R5
      (!state_reg.mon_run && !sw_clear && !auto_zero)
         |=> ($stable(state_reg.cyc) && $stable(state_reg.beat)))
      else $error("counters moved while halted");

   AST_SW_CLEAR: assert property (                                           // see R6
      sw_clear |=> (state_reg.cyc == CNT_RESET && state_reg.beat == CNT_RESET
                    && !state_reg.cyc_max && !state_reg.beat_max))
      else $error("clear bit did not zero counters");

   AST_AUTO_STOP: assert property (                                          // see R7
      (state_reg.mon_auto && stop_desc_done_in && !wr_ctrl) |=> !state_reg.mon_run)
      else $error("auto mode did not stop on stop descriptor");

   AST_AUTO_ZERO: assert property (                                          // see R8
      ((state_reg.mon_auto && !chan_run_in) ##1 (state_reg.mon_auto && chan_run_in))
         |=> (state_reg.cyc == CNT_RESET && state_reg.beat == CNT_RESET))
      else $error("auto mode did not zero counters on run edge");

   AST_CYC_STEP: assert property (                                           // see R11
      (counting && !sw_clear && !auto_zero && state_reg.cyc != CNT_MAX)
         |=> state_reg.cyc == $past(state_reg.cyc) + CNT_ONE)
      else $error("cycle counter did not step by one");

   AST_CYC_FLAG: assert property (                                           // see R12
      (state_reg.cyc == CNT_MAX) |-> state_reg.cyc_max)
      else $error("cycle flag missing at maximum");

   AST_BEAT_STEP: assert property (                                          // see R13
      (counting && rd_beat_valid_in && !sw_clear && !auto_zero
       && state_reg.beat != CNT_MAX) |=> state_reg.beat == $past(state_reg.beat) + CNT_ONE)
      else $error("beat counter did not step on valid beat");

   AST_BEAT_FLAG: assert property (                                          // see R14
      (state_reg.beat == CNT_MAX) |-> state_reg.beat_max)
      else $error("beat flag missing at maximum");

   AST_SATURATE: assert property (                                           // see R16
      (state_reg.cyc == CNT_MAX && !sw_clear && !auto_zero) |=> state_reg.cyc == CNT_MAX)
      else $error("cycle counter wrapped past maximum");

   AST_BEAT_SAT: assert property (                                           // see R16
      (state_reg.beat == CNT_MAX && !sw_clear && !auto_zero) |=> state_reg.beat == CNT_MAX)
      else $error("beat counter wrapped past maximum");

   AST_RUN_ARM: assert property (                                            // see R4
      (wr_ctrl && reg_wdata_in[CTRL_RUN_BIT]) |=> state_reg.mon_run)
      else $error("monitor run write did not arm the counters");

   AST_HALT_WRITE: assert property (                                         // see R5
      (wr_ctrl && !reg_wdata_in[CTRL_RUN_BIT]) |=> !state_reg.mon_run)
      else $error("monitor run write of zero did not halt the counters");

   AST_CLEAR_NOT_STORED: assert property (                                   // see R6
      (reg_rd_in && reg_addr_in == OFF_CTRL) |=> !reg_rdata_out[CTRL_CLEAR_BIT])
      else $error("clear bit read back as set");

   AST_NO_REZERO: assert property (                                          // see R9
      (chan_run_in && $past(chan_run_in) && counting && !sw_clear
       && state_reg.cyc != CNT_MAX) |=> state_reg.cyc != CNT_RESET)
      else $error("counters zeroed without a channel run edge");

   AST_CYC_READ: assert property (                                           // see R11
      (reg_rd_in && reg_addr_in == OFF_CYC_LO) |=> reg_rdata_out == $past(state_reg.cyc[LO_W-1:0]))
      else $error("cycle low word read back wrong");

   AST_CNT_READONLY: assert property (                                       // see R15
      (reg_wr_in && reg_addr_in == OFF_CYC_LO && !counting && !auto_zero)
         |=> $stable(state_reg.cyc))
      else $error("write to cycle counter word changed the count");

   COV_COUNTING: cover property (counting [*4]);
   COV_AUTO_STOP: cover property (state_reg.mon_auto && stop_desc_done_in && counting);
   COV_AUTO_ZERO: cover property (auto_zero);
   COV_IRQ: cover property (chan_irq_out);
endmodule

// ---- verification/c2h_channel_perf_monitor_tb.sv ----
/*
   self-checking testbench of the card_to_host channel performance monitor:
   mask aliases, interrupt gating, counting, clear and auto mode.
   assumes the design module c2h_perf_monitor and package c2h_perf_pkg.
*/
`timescale 1ns/1ps
module c2h_channel_perf_monitor_tb;
   import c2h_perf_pkg::*;
   logic              clk_in;
   logic              rst_n_in;
   logic [ADDR_W-1:0] reg_addr_in;
   logic              reg_wr_in;
   logic [DATA_W-1:0] reg_wdata_in;
   logic              reg_rd_in;
   logic [DATA_W-1:0] reg_rdata_out;
   logic              chan_run_in;
   logic              stop_desc_done_in;
   logic              rd_beat_valid_in;
   logic [DATA_W-1:0] status_events_in;
   logic [DATA_W-1:0] int_mask_out;
   logic              chan_irq_out;
   logic [DATA_W-1:0] v1;
   logic [DATA_W-1:0] v2;
   logic [DATA_W-1:0] exp_mask;
   int                n_mismatch = 0;
   int                num_checks = 0;

   c2h_perf_monitor DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
      .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out), .chan_run_in(chan_run_in),
      .stop_desc_done_in(stop_desc_done_in), .rd_beat_valid_in(rd_beat_valid_in),
      .status_events_in(status_events_in), .int_mask_out(int_mask_out),
      .chan_irq_out(chan_irq_out));

   always #20 clk_in = ~clk_in;

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk32(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      num_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // register tasks start at a falling edge and leave one idle edge behind them
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_addr_in  = a;
      reg_wdata_in = d;
      reg_wr_in    = 1'b1;
      @(negedge clk_in);
      reg_wr_in    = 1'b0;
      @(negedge clk_in);
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] q);
      reg_addr_in = a;
      reg_rd_in   = 1'b1;
      @(negedge clk_in);
      reg_rd_in   = 1'b0;
      q           = reg_rdata_out;
      @(negedge clk_in);
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      logic [DATA_W-1:0] q;
      rd(a, q);
      chk32(q, exp);
   endtask

   task automatic reset_values();
      rd_chk(OFF_CTRL, WORD_ZERO);
      rd_chk(OFF_CYC_LO, WORD_ZERO);
      rd_chk(OFF_CYC_HI, WORD_ZERO);
      rd_chk(OFF_BEAT_LO, WORD_ZERO);
      rd_chk(OFF_BEAT_HI, WORD_ZERO);
      rd_chk(8'h10, WORD_ZERO);
   endtask

   task automatic mask_and_irq();
      wr(OFF_MASK_SET, 32'hFFFF_FFFF);
      chk32(int_mask_out, MASK_VALID);
      wr(OFF_MASK_CLR, 32'h0000_0006);
      exp_mask = MASK_VALID & ~32'h0000_0006;
      chk32(int_mask_out, exp_mask);
      wr(OFF_MASK_CLR, WORD_ZERO);
      wr(OFF_MASK_SET, WORD_ZERO);
      chk32(int_mask_out, exp_mask);
      rd_chk(OFF_MASK_SET, WORD_ZERO);
      // one event at a time, so a wrong bit position cannot hide behind another
      for (int i = 0; i < DATA_W; i++)
      begin
         status_events_in = 32'h0000_0001 << i;
         @(negedge clk_in);
         @(negedge clk_in);
         chk1(chan_irq_out, exp_mask[i]);
      end
      status_events_in = WORD_ZERO;
      wr(OFF_MASK, 32'hFFFF_FFFF);
      rd_chk(OFF_MASK, MASK_VALID);
   endtask

   task automatic count_and_halt();
      wr(OFF_CTRL, 32'h0000_0004);
      repeat (4) @(negedge clk_in);
      rd_chk(OFF_CYC_LO, WORD_ZERO);
      chan_run_in      = 1'b1;
      rd_beat_valid_in = 1'b1;
      repeat (4) @(negedge clk_in);
      rd_beat_valid_in = 1'b0;
      repeat (6) @(negedge clk_in);
      // the halting write's own edge still counts: 11 cycles, 4 beats
      wr(OFF_CTRL, WORD_ZERO);
      wr(OFF_CYC_LO, 32'hFFFF_FFFF);
      rd_chk(OFF_CYC_LO, 32'h0000_000B);
      rd_chk(OFF_CYC_HI, WORD_ZERO);
      rd_chk(OFF_BEAT_LO, 32'h0000_0004);
      rd_chk(OFF_BEAT_HI, WORD_ZERO);
      chan_run_in = 1'b0;
      wr(OFF_CTRL, 32'h0000_0002);
      rd_chk(OFF_CYC_LO, WORD_ZERO);
      rd_chk(OFF_BEAT_LO, WORD_ZERO);
      rd_chk(OFF_CTRL, WORD_ZERO);
   endtask

   task automatic auto_mode();
      wr(OFF_CTRL, 32'h0000_0004);
      chan_run_in      = 1'b1;
      rd_beat_valid_in = 1'b1;
      repeat (3) @(negedge clk_in);
      chan_run_in      = 1'b0;
      rd_beat_valid_in = 1'b0;
      // auto alone never arms, so monitor run is written together with it
      wr(OFF_CTRL, 32'h0000_0005);
      chan_run_in = 1'b1;
      repeat (5) @(negedge clk_in);
      stop_desc_done_in = 1'b1;
      @(negedge clk_in);
      stop_desc_done_in = 1'b0;
      rd_chk(OFF_CTRL, 32'h0000_0001);
      rd(OFF_CYC_LO, v1);
      repeat (5) @(negedge clk_in);
      rd(OFF_CYC_LO, v2);
      chk32(v2, v1);
      chk32(v1, 32'h0000_0005);
      rd_chk(OFF_BEAT_LO, WORD_ZERO);
      // re-arming while channel run stays high must not zero again
      wr(OFF_CTRL, 32'h0000_0005);
      repeat (3) @(negedge clk_in);
      wr(OFF_CTRL, WORD_ZERO);
      rd_chk(OFF_CYC_LO, v1 + 32'h0000_0005);
   endtask

   initial
   begin
      clk_in            = 1'b0;
      rst_n_in          = 1'b0;
      reg_addr_in       = 8'h00;
      reg_wr_in         = 1'b0;
      reg_wdata_in      = WORD_ZERO;
      reg_rd_in         = 1'b0;
      chan_run_in       = 1'b0;
      stop_desc_done_in = 1'b0;
      rd_beat_valid_in  = 1'b0;
      status_events_in  = WORD_ZERO;
      repeat (4) @(negedge clk_in);
      rst_n_in = 1'b1;
      @(negedge clk_in);
      reset_values();
      mask_and_irq();
      count_and_halt();
      auto_mode();
      results();
   end

   // the whole run is under two hundred cycles; this leaves ample margin
   initial
   begin
      #100000;
      n_mismatch++;
      results();
   end
endmodule
